// ==== adc_and_timed_fault_response.sv ====
/*
 * Fault response for one supply channel: faults measured by the slow converter
 * (over/under temperature, input over/undervoltage) and the turn-on timeout.
 * Assumes fault inputs are same-clock levels from the measurement logic, the
 * control and bias sense pins are asynchronous, and the command decoder hands
 * over one register access per valid cycle.
 */
// What this block does
// R1: Action code zero keeps the channel running through a measured fault.
// R2: Nonzero action shuts down, immediately or sequenced after the turn-off delay.
// R3: Retry field zero means no restart; output stays latched off until released.
// R4: Nonzero retry restarts up to global count; off command, bias loss, fault stop it.
// R5: Measured-fault delay field reads zero; no deglitch before acting.
// R6: Temperature or input fault sets summary, detail bits and pulls alert low.
// R7: Turn-on timeout sets high-byte, vout word and timeout detail bits, asserts alert.
// R8: Timeout with nonzero action shuts down like other faults, then follows retry.
// R9: Timeout delay field is fixed zero; act at once on detection.
// R10: A fault shutdown with a zero retry field or no retries left latches the channel off.
// R11: Latch releases on control pin toggle, operation command, or bias removal.
// R12: Every fault and warning asserts alert and sets its status bits.
// R13: Clear-faults wipes status and releases alert but never releases a latched channel.
// R14: Measured faults are acted on straight from the converter, unfiltered.
// R15: Sequenced turn-off delay is clamped to 13.1 s internally; readback unchanged.
// R16: Status byte bit 0 flags faults or warnings not shown by bits 7 to 1.
// R17: Each restart reruns turn-on and decrements a retry counter; zero stays latched.
// R18: Host answers alert by reading status, then issues clear-faults.
`default_nettype none

module adc_and_timed_fault_response
    import fault_resp_pkg::*;
#(
    parameter logic [20:0] TOFF_LIMIT_TICKS = TOFF_MAX_TICKS
)(
    // Clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_nrst,
    // Register access from the command decoder
    input  wire logic        i_cmd_valid,
    input  wire logic        i_cmd_write,
    input  wire logic [3:0]  i_cmd_sel,
    input  wire logic [7:0]  i_cmd_wdata,
    input  wire logic        i_clear_faults,
    input  wire logic        i_op_cmd,
    input  wire logic        i_op_on,
    // Channel configuration
    input  wire logic        i_seq_off_mode,
    input  wire logic [20:0] i_toff_delay,
    input  wire logic [2:0]  i_retry_count,
    // Fault and warning events
    input  wire logic        i_ot_fault,
    input  wire logic        i_ut_fault,
    input  wire logic        i_vin_ov_fault,
    input  wire logic        i_vin_uv_fault,
    input  wire logic        i_ton_max_fault,
    input  wire logic        i_warn_event,
    // Pins
    input  wire logic        i_control_pin,
    input  wire logic        i_bias_sense_input,
    // Read answer
    output logic      [15:0] o_rd_data,
    output logic             o_rd_valid,
    // Channel control
    output logic             o_chan_on,
    output logic             o_turn_on_start,
    output logic             o_latched_off,
    // Open-drain alert toward the host
    output logic             o_host_alert_n_out,
    output logic             o_host_alert_n_oe
);

    // ==========================================================================
    // State
    // ==========================================================================
    typedef enum logic [2:0] {
        ST_OFF,
        ST_ON,
        ST_SEQ_OFF,
        ST_GAP,
        ST_LATCHED
    } chan_state_e;

    typedef struct packed {
        chan_state_e          st;
        logic [4:0][7:0]      rx;
        logic [2:0]           retry_fld;
        logic [2:0]           retry_cnt;
        logic [8:0]           tick_cnt;
        logic [20:0]          off_cnt;
        logic [3:0]           gap_cnt;
        logic                 ctrl_prev;
        logic                 f_ot;
        logic                 f_ut;
        logic                 f_vin_ov;
        logic                 f_vin_uv;
        logic                 f_ton_max;
        logic                 f_warn;
        logic                 alert;
        logic                 pin_level;
        logic                 chan_on;
        logic                 latched;
        logic                 turn_on_start;
        logic [15:0]          rd_data;
        logic                 rd_valid;
        logic [3:0]           rd_sel;
    } resp_s;

    resp_s r_reg;
    resp_s r_next;

    // ==========================================================================
    // Helpers
    // ==========================================================================
    function automatic logic act_on(input logic [7:0] rx);
        act_on = (rx[ACT_HI:ACT_LO] != 2'b00);
    endfunction

    function automatic chan_state_e after_off(input logic [2:0] fld, input logic [2:0] cnt);
        after_off = ((fld != 3'h0) && (cnt != 3'h0)) ? ST_GAP : ST_LATCHED;
    endfunction

    // ==========================================================================
    // Pin synchronisation
    // ==========================================================================
    logic [1:0] pins_s;
    logic       ctrl_s;
    logic       bias_s;

    pin_sync u_pin_sync (
        .i_clk_sys (i_clk_sys),
        .i_nrst    (i_nrst),
        .i_pins    ({i_bias_sense_input, i_control_pin}),
        .o_pins    (pins_s)
    );

    assign ctrl_s = pins_s[0];
    assign bias_s = pins_s[1];

    // ==========================================================================
    // Fault decode
    // ==========================================================================
    logic [4:0]  flt;
    logic [4:0]  shut_hit;
    logic [2:0]  hit_retry;
    logic [20:0] toff_eff;
    logic        run_ok;
    logic        release_req;
    logic        any_event;

    // Measured faults arrive unfiltered and act the same cycle
    assign flt = {i_ton_max_fault, i_vin_uv_fault, i_vin_ov_fault, i_ut_fault, i_ot_fault}; // R14

    genvar gi;
    generate
        for (gi = 0; gi < NUM_REACT; gi++) begin : g_hit
            assign shut_hit[gi] = flt[gi] & act_on(r_reg.rx[gi]); // R2 R8
        end
    endgenerate

    // Lowest index wins when several faults land together
    always_comb begin
        hit_retry = 3'h0;
        for (int k = NUM_REACT - 1; k >= 0; k--) begin
            if (shut_hit[k]) begin
                hit_retry = r_reg.rx[k][RETRY_HI:RETRY_LO];
            end
        end
    end

    // Only the internal copy is clamped; the delay input itself is untouched
    assign toff_eff = (i_toff_delay > TOFF_LIMIT_TICKS) ? TOFF_LIMIT_TICKS : i_toff_delay; // R15

    assign run_ok      = i_op_on & ctrl_s & bias_s;
    assign release_req = (ctrl_s != r_reg.ctrl_prev) | i_op_cmd | !bias_s; // R11
    assign any_event   = (|flt) | i_warn_event;

    // ==========================================================================
    // Next state
    // ==========================================================================
    always_comb begin
        r_next               = r_reg;
        r_next.turn_on_start = 1'b0;
        r_next.rd_valid      = 1'b0;
        r_next.pin_level     = 1'b0;
        r_next.ctrl_prev     = ctrl_s;
        if (r_reg.st != ST_GAP) begin
            r_next.gap_cnt = 4'h0;
        end

        // Register writes; delay field is hard-wired
        if (i_cmd_valid && i_cmd_write && (i_cmd_sel <= SEL_TON_MAX)) begin
            r_next.rx[i_cmd_sel[2:0]] = {i_cmd_wdata[ACT_HI:RETRY_LO], DELAY_FIXED}; // R5 R9
        end

        // Register reads
        if (i_cmd_valid && !i_cmd_write) begin
            r_next.rd_valid = 1'b1;
            r_next.rd_sel   = i_cmd_sel;
            r_next.rd_data  = 16'h0000;
            case (i_cmd_sel)
                SEL_OT, SEL_UT, SEL_VIN_OV, SEL_VIN_UV, SEL_TON_MAX: begin
                    r_next.rd_data[7:0] = r_reg.rx[i_cmd_sel[2:0]];
                end
                SEL_STATUS_BYTE, SEL_STATUS_WORD: begin
                    r_next.rd_data[SB_OFF]       = !r_reg.chan_on;
                    r_next.rd_data[SB_VIN_UV]    = r_reg.f_vin_uv;
                    r_next.rd_data[SB_TEMP]      = r_reg.f_ot | r_reg.f_ut;
                    r_next.rd_data[SB_HIGH_BYTE] = r_reg.f_vin_ov | r_reg.f_ton_max
                                                 | r_reg.f_warn; // R16
                    if (i_cmd_sel == SEL_STATUS_WORD) begin
                        r_next.rd_data[SW_VOUT]  = r_reg.f_ton_max;
                        r_next.rd_data[SW_INPUT] = r_reg.f_vin_ov | r_reg.f_vin_uv;
                    end
                end
                SEL_STATUS_INPUT: begin
                    r_next.rd_data[INPUT_OV_BIT] = r_reg.f_vin_ov;
                    r_next.rd_data[INPUT_UV_BIT] = r_reg.f_vin_uv;
                end
                SEL_STATUS_TEMP: begin
                    r_next.rd_data[TEMP_OT_BIT] = r_reg.f_ot;
                    r_next.rd_data[TEMP_UT_BIT] = r_reg.f_ut;
                end
                SEL_STATUS_VOUT: begin
                    r_next.rd_data[VOUT_TMAX_BIT] = r_reg.f_ton_max;
                end
                default: begin
                    r_next.rd_data = 16'h0000;
                end
            endcase
        end

        // Status flags: clear first so a same-cycle event survives
        if (i_clear_faults) begin
            r_next.f_ot      = 1'b0; // R13
            r_next.f_ut      = 1'b0;
            r_next.f_vin_ov  = 1'b0;
            r_next.f_vin_uv  = 1'b0;
            r_next.f_ton_max = 1'b0;
            r_next.f_warn    = 1'b0;
            r_next.alert     = 1'b0;
        end
        if (i_ot_fault) r_next.f_ot = 1'b1; // R6
        if (i_ut_fault) r_next.f_ut = 1'b1; // R6
        if (i_vin_ov_fault) r_next.f_vin_ov = 1'b1; // R6
        if (i_vin_uv_fault) r_next.f_vin_uv = 1'b1; // R6
        if (i_ton_max_fault) r_next.f_ton_max = 1'b1; // R7
        if (i_warn_event) r_next.f_warn = 1'b1; // R12
        if (any_event) r_next.alert = 1'b1; // R12

        // Channel sequencing
        case (r_reg.st)
            ST_OFF: begin
                if (run_ok) begin
                    r_next.st            = ST_ON;
                    r_next.turn_on_start = 1'b1;
                    r_next.retry_cnt     = i_retry_count;
                end
            end
            ST_ON: begin
                // Action zero faults fall through and the channel keeps running
                if (!run_ok) begin
                    r_next.st = ST_OFF;
                end else if (|shut_hit) begin
                    r_next.retry_fld = hit_retry;
                    if (i_seq_off_mode && (toff_eff != 21'h0)) begin
                        r_next.st       = ST_SEQ_OFF; // R2 R8
                        r_next.off_cnt  = toff_eff;
                        r_next.tick_cnt = 9'h000;
                    end else begin
                        r_next.st = after_off(hit_retry, r_reg.retry_cnt); // R2 R3 R10
                    end
                end
            end
            ST_SEQ_OFF: begin
                if (!run_ok) begin
                    r_next.st = ST_OFF;
                end else if (r_reg.tick_cnt == TICK_LAST) begin
                    r_next.tick_cnt = 9'h000;
                    if (r_reg.off_cnt == 21'h1) begin
                        r_next.st = after_off(r_reg.retry_fld, r_reg.retry_cnt); // R3 R10
                    end else begin
                        r_next.off_cnt = r_reg.off_cnt - 21'h1;
                    end
                end else begin
                    r_next.tick_cnt = r_reg.tick_cnt + 9'h001;
                end
            end
            ST_GAP: begin
                if (!run_ok) begin
                    r_next.st = ST_OFF; // R4
                end else if (|shut_hit) begin
                    r_next.st = ST_LATCHED; // R4
                end else if (r_reg.gap_cnt == RESTART_GAP_LAST) begin
                    r_next.st            = ST_ON; // R17
                    r_next.turn_on_start = 1'b1;
                    r_next.retry_cnt     = r_reg.retry_cnt - 3'h1; // R17
                end else begin
                    r_next.gap_cnt = r_reg.gap_cnt + 4'h1;
                end
            end
            ST_LATCHED: begin
                // Clear-faults deliberately has no path out of here
                if (release_req) begin
                    r_next.st = ST_OFF; // R11
                end
            end
            default: begin
                r_next.st = ST_OFF;
            end
        endcase

        r_next.chan_on = (r_next.st == ST_ON) || (r_next.st == ST_SEQ_OFF); // R1
        r_next.latched = (r_next.st == ST_LATCHED); // R10
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            r_reg     <= '0;
            r_reg.st  <= ST_OFF;
            r_reg.rx  <= {NUM_REACT{REACTION_RST}};
        end else begin
            r_reg <= r_next;
        end
    end

    assign o_rd_data          = r_reg.rd_data;
    assign o_rd_valid         = r_reg.rd_valid;
    assign o_chan_on          = r_reg.chan_on;
    assign o_turn_on_start    = r_reg.turn_on_start;
    assign o_latched_off      = r_reg.latched;
    assign o_host_alert_n_out = r_reg.pin_level;
    assign o_host_alert_n_oe  = r_reg.alert;

    // ==========================================================================
    // Assertions
    // ==========================================================================
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);

    sequence s_hit_on;
        r_reg.st == ST_ON && run_ok && (|shut_hit);
    endsequence

    sequence s_gap_done;
        r_reg.st == ST_GAP && run_ok && !(|shut_hit) && r_reg.gap_cnt == RESTART_GAP_LAST;
    endsequence

    a_keep_running: assert property ( // R1
        (r_reg.st == ST_ON && run_ok && (|flt) && !(|shut_hit)) |=> o_chan_on
    ) else $error("channel dropped on a fault with zero action");

    a_shut_now: assert property ( // R2
        s_hit_on ##0 !i_seq_off_mode |=> !o_chan_on
    ) else $error("immediate shutdown did not happen");

    a_seq_off_hold: assert property ( // R8
        s_hit_on ##0 (i_seq_off_mode && toff_eff > 21'h1)
        |=> (o_chan_on && r_reg.st == ST_SEQ_OFF)[*2]
    ) else $error("sequenced turn-off did not hold the channel");

    a_no_retry_latch: assert property ( // R3
        s_hit_on ##0 (!i_seq_off_mode && hit_retry == 3'h0) |=> o_latched_off && !o_chan_on
    ) else $error("zero retry field did not latch the channel off");

    a_retry_step: assert property ( // R4
        s_gap_done |=> o_turn_on_start && o_chan_on
                       && r_reg.retry_cnt == $past(r_reg.retry_cnt) - 3'h1
    ) else $error("restart attempt did not rerun turn-on with one fewer retry");

    a_delay_zero: assert property ( // R5
        o_rd_valid && r_reg.rd_sel <= SEL_TON_MAX |-> o_rd_data[DELAY_HI:0] == DELAY_FIXED
    ) else $error("reaction delay field read back nonzero");

    a_fault_flags: assert property ( // R6
        i_ot_fault || i_vin_uv_fault
        |=> (r_reg.f_ot || r_reg.f_vin_uv) && o_host_alert_n_oe && !o_host_alert_n_out
    ) else $error("measured fault did not flag status and pull alert");

    a_timeout_flags: assert property ( // R7
        i_ton_max_fault ##1 (!i_clear_faults)[*4]
        ##1 (i_cmd_valid && !i_cmd_write && i_cmd_sel == SEL_STATUS_WORD)
        |=> o_rd_data[SW_VOUT] && o_rd_data[SB_HIGH_BYTE]
    ) else $error("timeout fault missing from status word");

    a_hold_latch: assert property ( // R10
        o_latched_off && !release_req |=> o_latched_off && !o_chan_on
    ) else $error("latched channel left the off state without a release");

    a_clear_keeps_off: assert property ( // R13
        i_clear_faults && !any_event && o_latched_off && !release_req
        |=> !o_host_alert_n_oe && o_latched_off
    ) else $error("clear-faults misbehaved on a latched channel");

    a_toff_bound: assert property ( // R15
        r_reg.st == ST_SEQ_OFF |-> r_reg.off_cnt <= TOFF_LIMIT_TICKS
    ) else $error("turn-off delay exceeded its internal limit");

endmodule

`default_nettype wire

// ==== fault_resp_pkg.sv ====
/*
 * Shared constants for the converter-measured and turn-on timeout fault response block:
 * timing counts, reaction register field layout, register selector codes and status bit
 * positions.
 * Assumes a 50 MHz system clock; the tick counts below are derived from it.
 */
`default_nettype none

package fault_resp_pkg;

    // ==========================================================================
    // Timing
    // ==========================================================================
    localparam int          CLK_HZ         = 50_000_000;
    localparam int          TICK_US        = 10;
    localparam int          TICK_CYCLES    = TICK_US * (CLK_HZ / 1_000_000);
    localparam logic [8:0]  TICK_LAST      = 9'(TICK_CYCLES - 1);
    localparam int          TOFF_MAX_MS    = 13_100;
    localparam logic [20:0] TOFF_MAX_TICKS = 21'(TOFF_MAX_MS * 1000 / TICK_US);
    // Off time between a fault shutdown and the next restart attempt
    localparam logic [3:0]  RESTART_GAP_LAST = 4'h7;

    // ==========================================================================
    // Reaction register layout
    // ==========================================================================
    localparam int          ACT_HI       = 7;
    localparam int          ACT_LO       = 6;
    localparam int          RETRY_HI     = 5;
    localparam int          RETRY_LO     = 3;
    localparam int          DELAY_HI     = 2;
    localparam logic [2:0]  DELAY_FIXED  = 3'h0;
    localparam logic [7:0]  REACTION_RST = 8'h80;
    localparam int          NUM_REACT    = 5;

    // ==========================================================================
    // Register selectors on the command port
    // ==========================================================================
    localparam logic [3:0]  SEL_OT           = 4'h0;
    localparam logic [3:0]  SEL_UT           = 4'h1;
    localparam logic [3:0]  SEL_VIN_OV       = 4'h2;
    localparam logic [3:0]  SEL_VIN_UV       = 4'h3;
    localparam logic [3:0]  SEL_TON_MAX      = 4'h4;
    localparam logic [3:0]  SEL_STATUS_BYTE  = 4'h5;
    localparam logic [3:0]  SEL_STATUS_WORD  = 4'h6;
    localparam logic [3:0]  SEL_STATUS_INPUT = 4'h7;
    localparam logic [3:0]  SEL_STATUS_TEMP  = 4'h8;
    localparam logic [3:0]  SEL_STATUS_VOUT  = 4'h9;

    // ==========================================================================
    // Status bit positions
    // ==========================================================================
    localparam int          SB_OFF        = 6;
    localparam int          SB_VIN_UV     = 3;
    localparam int          SB_TEMP       = 2;
    localparam int          SB_HIGH_BYTE  = 0;
    localparam int          SW_VOUT       = 15;
    localparam int          SW_INPUT      = 13;
    localparam int          TEMP_OT_BIT   = 7;
    localparam int          TEMP_UT_BIT   = 4;
    localparam int          INPUT_OV_BIT  = 7;
    localparam int          INPUT_UV_BIT  = 4;
    localparam int          VOUT_TMAX_BIT = 4;

endpackage

`default_nettype wire

// ==== pin_sync.sv ====
/*
 * Two-stage synchroniser for the channel control pin and the bias sense pin.
 * Assumes both pins are asynchronous levels; only the second stage is used downstream.
 */
`default_nettype none

module pin_sync
    import fault_resp_pkg::*;
(
    // Clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_nrst,
    // Raw pins
    input  wire logic [1:0] i_pins,
    // Synchronised levels
    output logic      [1:0] o_pins
);

    typedef struct packed {
        logic [1:0] stage1;
        logic [1:0] stage2;
    } sync_s;

    sync_s sync_reg;
    sync_s sync_next;

    always_comb begin
        sync_next = sync_reg;
        for (int k = 0; k < 2; k++) begin
            sync_next.stage1[k] = i_pins[k];
            sync_next.stage2[k] = sync_reg.stage1[k];
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            sync_reg <= '0;
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign o_pins = sync_reg.stage2;

endmodule

`default_nettype wire

// ==== host_model.sv ====
/* Host partner: answers an asserted alert with a clear-faults pulse.
   Assumes the bench reads the status registers before raising i_en. */
`default_nettype none
module host_model (
    input  wire logic i_clk_sys,
    input  wire logic i_nrst,
    input  wire logic i_en,
    input  wire logic i_host_alert_n,
    output logic      o_clear_faults
);
    timeunit 1ns;
    timeprecision 1ns;
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            o_clear_faults <= 1'b0;
        end else begin
            // Pulse only; a held alert must not be cleared every cycle
            o_clear_faults <= i_en && !i_host_alert_n && !o_clear_faults;
        end
    end
endmodule
`default_nettype wire

// ==== adc_and_timed_fault_response_tb_top.sv ====
/* Self-checking bench for the fault response block.
   Assumes a shortened turn-off clamp of 20 ticks and a pulled-up alert line. */
`default_nettype none
module adc_and_timed_fault_response_tb_top
    import fault_resp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, nrst, vld, wr, hen, op_cmd, op_on, seq, ctrl, bias;
    logic [3:0]  sel;
    logic [2:0]  rcnt;
    logic [7:0]  wd;
    logic [20:0] toff;
    logic [5:0]  flt;
    logic [15:0] d;
    logic [31:0] rnd;
    wire  [15:0] rdd;
    wire         rv, on, lat, aout, aoe, clr, tos;
    wire         alert_n = aoe ? aout : 1'b1;
    int          fails, check_count;
    adc_and_timed_fault_response #(.TOFF_LIMIT_TICKS(21'h14)) uut (
        .i_clk_sys(clk), .i_nrst(nrst), .i_cmd_valid(vld), .i_cmd_write(wr),
        .i_cmd_sel(sel), .i_cmd_wdata(wd), .i_clear_faults(clr), .i_op_cmd(op_cmd),
        .i_op_on(op_on), .i_seq_off_mode(seq), .i_toff_delay(toff), .i_retry_count(rcnt),
        .i_ot_fault(flt[0]), .i_ut_fault(flt[1]), .i_vin_ov_fault(flt[2]),
        .i_vin_uv_fault(flt[3]), .i_ton_max_fault(flt[4]), .i_warn_event(flt[5]),
        .i_control_pin(ctrl), .i_bias_sense_input(bias), .o_rd_data(rdd), .o_rd_valid(rv),
        .o_chan_on(on), .o_turn_on_start(tos), .o_latched_off(lat),
        .o_host_alert_n_out(aout), .o_host_alert_n_oe(aoe));
    host_model host (.i_clk_sys(clk), .i_nrst(nrst), .i_en(hen),
        .i_host_alert_n(alert_n), .o_clear_faults(clr));
    // ==========================================================
    // Expectations
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [15:0] exp_word(input int i);
        case (i)
            0, 1: return 16'h0004;
            2: return 16'h2001;
            3: return 16'h2008;
            4: return 16'h8001;
            default: return 16'h0001;
        endcase
    endfunction
    function automatic logic [3:0] dsel(input int i);
        return i < 2 ? SEL_STATUS_TEMP : i < 4 ? SEL_STATUS_INPUT :
               i == 4 ? SEL_STATUS_VOUT : SEL_STATUS_WORD;
    endfunction
    // ==========================================================
    // Tasks
    task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        check_count++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic wrr(input logic [3:0] s, input logic [7:0] v);
        @(posedge clk);
        vld <= 1'b1;
        wr <= 1'b1;
        sel <= s;
        wd <= v;
        @(posedge clk);
        vld <= 1'b0;
        wr <= 1'b0;
    endtask
    // Answer must stand right after the taking edge, checked 1 ns later
    task automatic rd(input logic [3:0] s);
        @(posedge clk);
        vld <= 1'b1;
        sel <= s;
        @(posedge clk);
        vld <= 1'b0;
        #1;
        chk("rd_valid", 16'(rv), 16'h1);
        d = rdd;
    endtask
    task automatic wt(input logic v, input int n);
        for (int k = 0; k < n && on !== v; k++) @(posedge clk) #1;
    endtask
    task automatic pulse(input int i);
        @(posedge clk);
        flt[i] <= 1'b1;
        @(posedge clk);
        flt <= '0;
    endtask
    task automatic hclr;
        @(posedge clk);
        hen <= 1'b1;
        for (int k = 0; k < 10 && alert_n !== 1'b1; k++) @(posedge clk) #1;
        @(posedge clk);
        hen <= 1'b0;
        chk("alert_clr", 16'(aoe), 16'h0);
    endtask
    // ==========================================================
    // Stimulus
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        repeat (30000) @(posedge clk);
        fails++;
        end_sim();
    end
    initial begin
        {nrst, vld, wr, hen, op_cmd, op_on, seq, ctrl, bias} = '0;
        {sel, wd, toff, flt, rcnt} = '0;
        rnd = 32'hF5A3;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            rd(4'(i));
            chk("react_rst", d, 16'h0080);
            rnd = lfsr(rnd);
            wrr(4'(i), rnd[7:0]);
            rd(4'(i));
            chk("react", d, {8'h00, rnd[7:3], 3'h0});
            wrr(4'(i), 8'h00);
        end
        rd(4'hF);
        chk("unmapped", d, 16'h0000);
        @(posedge clk);
        {op_on, ctrl, bias} <= 3'h7;
        rcnt <= 3'h1 + 3'(rnd[1:0]);
        wt(1'b1, 10);
        for (int i = 0; i < 6; i++) begin
            pulse(i);
            repeat (3) @(posedge clk);
            #1;
            chk("on_act0", 16'(on), 16'h1);
            chk("alert", 16'(aoe), 16'h1);
            chk("alert_pin", 16'(alert_n), 16'h0);
            rd(SEL_STATUS_WORD);
            chk("word", d, exp_word(i));
            rd(dsel(i));
            chk("detail", d, i == 5 ? 16'h1 : i[0] || i == 4 ? 16'h10 : 16'h80);
            hclr();
            rd(SEL_STATUS_WORD);
            chk("word_clr", d, 16'h0000);
        end
        // Release by command, control pin toggle and bias loss in turn
        for (int k = 0; k < 3; k++) begin
            wrr(SEL_OT, 8'h80);
            pulse(0);
            wt(1'b0, 4);
            hclr();
            repeat (5) @(posedge clk);
            #1;
            chk("latched", 16'({on, lat}), 16'h1);
            @(posedge clk);
            op_cmd <= (k == 0);
            ctrl <= (k != 1);
            bias <= (k != 2);
            @(posedge clk);
            op_cmd <= 1'b0;
            repeat (4) @(posedge clk);
            {ctrl, bias} <= 2'h3;
            wt(1'b1, 15);
            chk("release", 16'({on, lat}), 16'h2);
        end
        wrr(SEL_TON_MAX, 8'h88);
        for (int r = 0; r <= int'(rcnt); r++) begin
            pulse(4);
            wt(1'b0, 4);
            wt(1'b1, 20);
            chk("retry_on", 16'(on), 16'(r < rcnt));
            chk("restart_pulse", 16'(tos), 16'(r < rcnt));
        end
        chk("retry_lat", 16'(lat), 16'h1);
        @(posedge clk);
        op_cmd <= 1'b1;
        seq <= 1'b1;
        toff <= 21'd100;
        @(posedge clk);
        op_cmd <= 1'b0;
        wt(1'b1, 15);
        // Delay above the clamp: 20 ticks of 500 cycles
        pulse(0);
        repeat (9900) @(posedge clk);
        #1;
        chk("seq_hold", 16'(on), 16'h1);
        wt(1'b0, 300);
        chk("seq_off", 16'(on), 16'h0);
        end_sim();
    end
endmodule
`default_nettype wire
